// File: logic/port_c_pin_mux.sv
// Port C pin multiplexer with AXI4-Lite register access and peripheral overrides on seven pins.
// Assumes pads and peripherals are synchronous to ref_clk; the pad resolves wire levels from the enables.
`timescale 1ns/10ps
module port_c_pin_mux
    import port_c_pkg::*;
(
    input wire logic ref_clk, // System clock, 20 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [7:0] pin_in, // Pad input levels; bit 3 unused.
    output logic [7:0] pin_out, // Pad output levels.
    output logic [7:0] pin_oe, // Pad output enables, high drives.
    input wire logic large_package, // High on packages with PWM channel A.
    input wire logic timer_osc_enable, // Timer oscillator owns pins 0 and 1.
    output logic timer_counter_input, // Timer counter input from pin 0.
    input wire logic ccp_two_active, // Compare two in compare or PWM mode.
    input wire logic ccp_two_out, // Compare two output level.
    output logic ccp_two_capture, // Compare two capture input.
    input wire logic ccp_one_active, // Compare one in compare or PWM mode.
    input wire logic ccp_one_out, // Compare one output level.
    output logic ccp_one_capture, // Compare one capture input.
    input wire logic pwm_a_active, // Enhanced PWM channel A in use.
    input wire logic pwm_a_out, // PWM channel A level.
    input wire logic pwm_shutdown, // Enhanced PWM shutdown event in progress.
    input wire logic xcvr_output_enable, // Transceiver output enable from USB module.
    output logic xcvr_minus_input, // External transceiver minus data.
    output logic xcvr_plus_input, // External transceiver plus data.
    input wire logic usb_drive, // On-chip transceiver drives the bus now.
    input wire logic usb_minus_out, // On-chip minus line level.
    input wire logic usb_plus_out, // On-chip plus line level.
    output logic usb_minus_in, // On-chip minus line received.
    output logic usb_plus_in, // On-chip plus line received.
    input wire logic usart_tx_active, // Serial unit in asynchronous transmit mode.
    input wire logic usart_tx_out, // Asynchronous transmit data.
    output logic usart_rx_in, // Asynchronous receive data.
    input wire logic usart_sync_mode, // Serial unit in synchronous mode.
    input wire logic sync_serial_clock_out, // Synchronous clock out.
    output logic sync_serial_clock_in, // Synchronous clock in.
    input wire logic sync_serial_line_drive, // Synchronous data output active.
    input wire logic sync_serial_line_out, // Synchronous data out.
    output logic sync_serial_line_in, // Synchronous data in.
    input wire logic spi_active, // SPI data output enabled.
    input wire logic spi_serial_out, // SPI data out.
    output logic ccp_two_alt_out, // Compare two output for the alternate pin.
    output logic ccp_two_alt_oe // Compare two alternate pin enable.
);

    typedef struct packed {
        logic [7:0] output_latch_reg;
        logic [7:0] direction_reg;
        logic [7:0] usb_control_reg;
        logic [7:0] pin_config_reg;
        logic [7:0] pin_sample_reg;
        logic aw_held_reg;
        logic [7:0] aw_addr_reg;
        logic w_held_reg;
        logic [31:0] w_data_reg;
        logic [3:0] w_strb_reg;
        logic bvalid_reg;
        logic [1:0] bresp_reg;
        logic rvalid_reg;
        logic [31:0] rdata_reg;
        logic [1:0] rresp_reg;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // Decode a word address to its register; any other address is unmapped.
    function automatic logic addr_mapped(input logic [7:0] addr);
        if (addr == PIN_VALUE_OFFSET) begin
            addr_mapped = 1'b1;
        end else if (addr == OUTPUT_LATCH_OFFSET) begin
            addr_mapped = 1'b1;
        end else if (addr == DIRECTION_OFFSET) begin
            addr_mapped = 1'b1;
        end else if (addr == USB_CONTROL_OFFSET) begin
            addr_mapped = 1'b1;
        end else if (addr == PIN_CONFIG_OFFSET) begin
            addr_mapped = 1'b1;
        end else begin
            addr_mapped = 1'b0;
        end
    endfunction : addr_mapped

    logic timer_osc_on;
    logic ccp_two_here;
    logic ext_xcvr;
    logic onchip_on;
    logic usb_en;
    logic port_in_ok;
    logic [7:0] dir_eff;
    logic [7:0] latch;
    logic [7:0] pin_value_view;

    // Mode decode shared by output selection and input routing.
    always_comb begin
        latch = state_reg.output_latch_reg;
        dir_eff = state_reg.direction_reg;
        usb_en = state_reg.usb_control_reg[USB_ENABLE_BIT];
        timer_osc_on = timer_osc_enable | state_reg.pin_config_reg[CFG_TIMER_OSC_BIT];
        ccp_two_here = state_reg.pin_config_reg[CFG_CCP_TWO_SEL_BIT];
        ext_xcvr = usb_en & state_reg.pin_config_reg[CFG_XCVR_EXT_BIT];
        onchip_on = ~state_reg.pin_config_reg[CFG_ONCHIP_XCVR_OFF_BIT];
        port_in_ok = ~usb_en & ~onchip_on;
    end

    // Fixed-priority output selection per pin; the highest listed source wins.
    always_comb begin
        pin_out = 8'h00;
        pin_oe = 8'h00;
        // Pin 0: oscillator disables digital drive altogether.
        if (!timer_osc_on) begin
            pin_out[0] = latch[0];
            pin_oe[0] = ~dir_eff[0];
        end
        // Pin 1: oscillator, then transceiver enable, then compare two, then latch.
        if (timer_osc_on) begin
            pin_oe[1] = 1'b0;
        end else if (ext_xcvr) begin
            pin_out[1] = xcvr_output_enable;
            pin_oe[1] = 1'b1;
        end else if (ccp_two_here && ccp_two_active && !dir_eff[1]) begin
            pin_out[1] = ccp_two_out;
            pin_oe[1] = 1'b1;
        end else begin
            pin_out[1] = latch[1];
            pin_oe[1] = ~dir_eff[1];
        end
        // Pin 2: PWM channel A may be tristated during shutdown.
        if (large_package && pwm_a_active && !dir_eff[2]) begin
            pin_out[2] = pwm_a_out;
            pin_oe[2] = ~(pwm_shutdown & state_reg.pin_config_reg[CFG_PWM_TRISTATE_BIT]);
        end else if (ccp_one_active && !dir_eff[2]) begin
            pin_out[2] = ccp_one_out;
            pin_oe[2] = 1'b1;
        end else begin
            pin_out[2] = latch[2];
            pin_oe[2] = ~dir_eff[2];
        end
        // Pins 4 and 5 drive only for the on-chip transceiver while it transmits.
        if (usb_en && onchip_on && !ext_xcvr && usb_drive) begin
            pin_out[4] = usb_minus_out;
            pin_out[5] = usb_plus_out;
            pin_oe[4] = 1'b1;
            pin_oe[5] = 1'b1;
        end
        // Pin 6: synchronous clock, then transmit, both only with direction zero.
        if (usart_sync_mode && !dir_eff[6]) begin
            pin_out[6] = sync_serial_clock_out;
            pin_oe[6] = 1'b1;
        end else if (usart_tx_active && !usart_sync_mode) begin
            pin_out[6] = usart_tx_out;
            pin_oe[6] = ~dir_eff[6];
        end else begin
            pin_out[6] = latch[6];
            pin_oe[6] = ~dir_eff[6];
        end
        // Pin 7: synchronous data first, then SPI, then latch.
        if (usart_sync_mode && sync_serial_line_drive) begin
            pin_out[7] = sync_serial_line_out;
            pin_oe[7] = 1'b1;
        end else if (spi_active && !dir_eff[7]) begin
            pin_out[7] = spi_serial_out;
            pin_oe[7] = 1'b1;
        end else begin
            pin_out[7] = latch[7];
            pin_oe[7] = ~dir_eff[7];
        end
    end

    // Input routing to peripherals; paths that are not allowed read as zero.
    always_comb begin
        timer_counter_input = ~timer_osc_on & dir_eff[0] & pin_in[0];
        ccp_two_capture = ccp_two_here & ~timer_osc_on & dir_eff[1] & pin_in[1];
        ccp_one_capture = dir_eff[2] & pin_in[2];
        xcvr_minus_input = ext_xcvr & pin_in[4];
        xcvr_plus_input = ext_xcvr & pin_in[5];
        usb_minus_in = usb_en & onchip_on & pin_in[4];
        usb_plus_in = usb_en & onchip_on & pin_in[5];
        sync_serial_clock_in = usart_sync_mode & dir_eff[6] & pin_in[6];
        usart_rx_in = ~usart_sync_mode & dir_eff[7] & pin_in[7];
        sync_serial_line_in = usart_sync_mode & dir_eff[7] & pin_in[7];
        ccp_two_alt_out = ccp_two_out;
        ccp_two_alt_oe = ~ccp_two_here & ccp_two_active;
        pin_value_view = state_reg.pin_sample_reg & PIN_VALUE_MASK;
        if (timer_osc_on) begin
            pin_value_view[1:0] = 2'h0;
        end
        if (!port_in_ok) begin
            pin_value_view[5:4] = 2'h0;
        end
    end

    // Bus handshake outputs come straight from the state.
    always_comb begin
        s_axi_awready = ~state_reg.aw_held_reg & ~state_reg.bvalid_reg;
        s_axi_wready = ~state_reg.w_held_reg & ~state_reg.bvalid_reg;
        s_axi_bvalid = state_reg.bvalid_reg;
        s_axi_bresp = state_reg.bresp_reg;
        s_axi_arready = ~state_reg.rvalid_reg;
        s_axi_rvalid = state_reg.rvalid_reg;
        s_axi_rdata = state_reg.rdata_reg;
        s_axi_rresp = state_reg.rresp_reg;
    end

    // Next state: pin sampling, write capture in any order, write commit, read answer.
    // Address and data are held until both arrive, so the response never precedes either.
    always_comb begin
        logic [7:0] wbyte;
        logic [7:0] waddr;
        wbyte = 8'h00;
        waddr = 8'h00;
        state_next = state_reg;
        state_next.pin_sample_reg = pin_in;
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_held_reg = 1'b1;
            state_next.aw_addr_reg = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_held_reg = 1'b1;
            state_next.w_data_reg = s_axi_wdata;
            state_next.w_strb_reg = s_axi_wstrb;
        end
        if (state_reg.aw_held_reg && state_reg.w_held_reg) begin
            waddr = state_reg.aw_addr_reg;
            wbyte = state_reg.w_data_reg[7:0];
            state_next.aw_held_reg = 1'b0;
            state_next.w_held_reg = 1'b0;
            state_next.bvalid_reg = 1'b1;
            state_next.bresp_reg = addr_mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
            if (state_reg.w_strb_reg[0]) begin
                // A write to the pin value register lands in the latch.
                if (waddr == PIN_VALUE_OFFSET || waddr == OUTPUT_LATCH_OFFSET) begin
                    state_next.output_latch_reg = wbyte & LATCH_DIR_MASK;
                end else if (waddr == DIRECTION_OFFSET) begin
                    state_next.direction_reg = wbyte & LATCH_DIR_MASK;
                end else if (waddr == USB_CONTROL_OFFSET) begin
                    state_next.usb_control_reg = wbyte & USB_CONTROL_MASK;
                end else if (waddr == PIN_CONFIG_OFFSET) begin
                    state_next.pin_config_reg = wbyte & PIN_CONFIG_MASK;
                end
            end
        end
        if (state_reg.bvalid_reg && s_axi_bready) begin
            state_next.bvalid_reg = 1'b0;
        end
        if (state_reg.rvalid_reg && s_axi_rready) begin
            state_next.rvalid_reg = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid_reg = 1'b1;
            state_next.rresp_reg = RESP_OKAY;
            state_next.rdata_reg = 32'h0000_0000;
            if ({s_axi_araddr[7:2], 2'b00} == PIN_VALUE_OFFSET) begin
                state_next.rdata_reg[7:0] = pin_value_view;
            end else if ({s_axi_araddr[7:2], 2'b00} == OUTPUT_LATCH_OFFSET) begin
                state_next.rdata_reg[7:0] = state_reg.output_latch_reg;
            end else if ({s_axi_araddr[7:2], 2'b00} == DIRECTION_OFFSET) begin
                state_next.rdata_reg[7:0] = state_reg.direction_reg;
            end else if ({s_axi_araddr[7:2], 2'b00} == USB_CONTROL_OFFSET) begin
                state_next.rdata_reg[7:0] = state_reg.usb_control_reg;
            end else if ({s_axi_araddr[7:2], 2'b00} == PIN_CONFIG_OFFSET) begin
                state_next.rdata_reg[7:0] = state_reg.pin_config_reg;
            end else begin
                state_next.rresp_reg = RESP_SLVERR;
            end
        end
    end

    // One register stage for the whole state; the enable freezes everything.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.direction_reg <= DIRECTION_RESET;
            state_reg.output_latch_reg <= LATCH_RESET;
            state_reg.usb_control_reg <= USB_CONTROL_RESET;
            state_reg.pin_config_reg <= PIN_CONFIG_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // Pins with direction one never drive unless an override owns them.
    property p_dir_input_tristate;
        @(posedge ref_clk) disable iff (rst)
        (state_reg.direction_reg[0] || timer_osc_on) |-> !pin_oe[0];
    endproperty
    a_dir_input_tristate: assert property (p_dir_input_tristate) else $error("Pin 0 drives as input.");

    property p_latch_readback;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == OUTPUT_LATCH_OFFSET)
            |=> s_axi_rdata[7:0] == $past(state_reg.output_latch_reg);
    endproperty
    a_latch_readback: assert property (p_latch_readback) else $error("Latch readback differs.");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (rst)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && pin_value_view[3] == 1'b0
            && state_reg.output_latch_reg[5:3] == 3'b000 && state_reg.direction_reg[5:3] == 3'b000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit reads one.");

    property p_osc_pin_one;
        @(posedge ref_clk) disable iff (rst)
        timer_osc_on |-> !pin_oe[1] && !ccp_two_capture;
    endproperty
    a_osc_pin_one: assert property (p_osc_pin_one) else $error("Oscillator pin used digitally.");

    property p_ext_xcvr_oe;
        @(posedge ref_clk) disable iff (rst)
        (ext_xcvr && !timer_osc_on) |-> pin_oe[1] && pin_out[1] == xcvr_output_enable;
    endproperty
    a_ext_xcvr_oe: assert property (p_ext_xcvr_oe) else $error("Enable not on pin 1.");

    property p_usb_pins_quiet;
        @(posedge ref_clk) disable iff (rst)
        !(usb_en && onchip_on && usb_drive) |-> pin_oe[5:4] == 2'b00;
    endproperty
    a_usb_pins_quiet: assert property (p_usb_pins_quiet) else $error("Pins 4 or 5 drive.");

    property p_port_in_gate;
        @(posedge ref_clk) disable iff (rst)
        !port_in_ok |-> pin_value_view[5:4] == 2'b00;
    endproperty
    a_port_in_gate: assert property (p_port_in_gate) else $error("Port input not gated.");

    property p_sync_line_first;
        @(posedge ref_clk) disable iff (rst)
        (usart_sync_mode && sync_serial_line_drive) |-> pin_oe[7] && pin_out[7] == sync_serial_line_out;
    endproperty
    a_sync_line_first: assert property (p_sync_line_first) else $error("Sync data lost priority.");

    property p_spi_over_latch;
        @(posedge ref_clk) disable iff (rst)
        (spi_active && !dir_eff[7] && !(usart_sync_mode && sync_serial_line_drive)) |-> pin_out[7] == spi_serial_out;
    endproperty
    a_spi_over_latch: assert property (p_spi_over_latch) else $error("SPI lost to latch.");

    property p_rx_gate;
        @(posedge ref_clk) disable iff (rst)
        !dir_eff[7] |-> !usart_rx_in && !sync_serial_line_in;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("Receive taken while output.");

endmodule : port_c_pin_mux

// File: logic/port_c_pkg.sv
// Package for the port C pin multiplexer: register offsets, field positions and reset values.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package port_c_pkg;
    localparam logic [7:0] PIN_VALUE_OFFSET = 8'h00;
    localparam logic [7:0] OUTPUT_LATCH_OFFSET = 8'h04;
    localparam logic [7:0] DIRECTION_OFFSET = 8'h08;
    localparam logic [7:0] USB_CONTROL_OFFSET = 8'h0C;
    localparam logic [7:0] PIN_CONFIG_OFFSET = 8'h10;
    // Implemented bit masks; pin 3 is absent, pins 4 and 5 have no latch or direction bit.
    localparam logic [7:0] PIN_VALUE_MASK = 8'hF7;
    localparam logic [7:0] LATCH_DIR_MASK = 8'hC7;
    localparam logic [7:0] USB_CONTROL_MASK = 8'h7E;
    localparam logic [7:0] PIN_CONFIG_MASK = 8'h1F;
    localparam int USB_ENABLE_BIT = 3;
    // Configuration bits held in the block's own register.
    localparam int CFG_TIMER_OSC_BIT = 0;
    localparam int CFG_CCP_TWO_SEL_BIT = 1;
    localparam int CFG_XCVR_EXT_BIT = 2;
    localparam int CFG_ONCHIP_XCVR_OFF_BIT = 3;
    localparam int CFG_PWM_TRISTATE_BIT = 4;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hC7;
    localparam logic [7:0] USB_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PIN_CONFIG_RESET = 8'h0A;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : port_c_pkg

// File: testbench/board_model.sv
// Board circuitry on the port pads: a driven pad shows the block's level, an undriven pad the board's own level.
// Assumes the board level is set by the bench; no pad is ever left floating.
`timescale 1ns/10ps
module board_model (
    input wire logic [7:0] pin_out, // Block pad levels.
    input wire logic [7:0] pin_oe, // Block pad enables.
    input wire logic [7:0] ext_level, // Level the board applies to released pads.
    output logic [7:0] pin_in // Resolved wire levels.
);
    // Resolution per pad, so a stale driven value never lingers after release.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : board_model

// File: testbench/port_c_pin_mux_test.sv
// Self-checking bench for the port C pin multiplexer over AXI4-Lite.
// Assumes the register map and reset values of port_c_pkg.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module port_c_pin_mux_test;
    import port_c_pkg::*;
    logic ref_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, ext = 8'h00, pin_out, pin_oe, pin_in;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [20:0] pv = 0;
    logic awready, wready, bvalid, arready, rvalid, cap2;
    wire [10:0] po;
    int n_mismatch = 0, checked = 0, cyc = 0;
    port_c_pin_mux dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .large_package(pv[0]), .timer_osc_enable(pv[1]), .timer_counter_input(po[0]), .ccp_two_active(pv[2]),
        .ccp_two_out(pv[3]), .ccp_two_capture(cap2), .ccp_one_active(pv[4]), .ccp_one_out(pv[5]),
        .ccp_one_capture(po[1]), .pwm_a_active(pv[6]), .pwm_a_out(pv[7]), .pwm_shutdown(pv[8]),
        .xcvr_output_enable(pv[9]), .xcvr_minus_input(po[2]), .xcvr_plus_input(po[3]), .usb_drive(pv[10]),
        .usb_minus_out(pv[11]), .usb_plus_out(pv[12]), .usb_minus_in(po[4]), .usb_plus_in(po[5]),
        .usart_tx_active(pv[13]), .usart_tx_out(pv[14]), .usart_rx_in(po[6]), .usart_sync_mode(pv[15]),
        .sync_serial_clock_out(pv[16]), .sync_serial_clock_in(po[7]), .sync_serial_line_drive(pv[17]),
        .sync_serial_line_out(pv[18]), .sync_serial_line_in(po[8]), .spi_active(pv[19]),
        .spi_serial_out(pv[20]), .ccp_two_alt_out(po[9]), .ccp_two_alt_oe(po[10]));
    board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
    // Clock at 50 ns.
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic conclude;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    // Ready is sampled at the falling edge, where it is settled, and acted on at the next rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ra, rw, rb;
        rb = 0;
        @(posedge ref_clk);
        awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!rb) begin
            @(negedge ref_clk);
            ra = awready; rw = wready; rb = bvalid;
            @(posedge ref_clk);
            if (ra) awvalid <= 0;
            if (rw) wvalid <= 0;
        end
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ra, rv;
        rv = 0;
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!rv) begin
            @(negedge ref_clk);
            ra = arready; rv = rvalid; d = rdata; r = rresp;
            @(posedge ref_clk);
            if (ra) arvalid <= 0;
        end
        rready <= 0;
    endtask : rd
    task automatic ck(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        `CHK(d, {24'h0, e})
    endtask : ck
    // Peripheral levels change at a rising edge; pads are judged at the following falling edge.
    task automatic setp(input logic [20:0] v);
        @(posedge ref_clk);
        pv <= v;
        @(negedge ref_clk);
    endtask : setp
    // Reset values, masked reserved bits and an unmapped address.
    task automatic t_regs;
        ck(DIRECTION_OFFSET, DIRECTION_RESET);
        ck(PIN_CONFIG_OFFSET, PIN_CONFIG_RESET);
        `CHK(pin_oe, 8'h00)
        wr(OUTPUT_LATCH_OFFSET, 8'hFF);
        ck(OUTPUT_LATCH_OFFSET, 8'hC7);
        rd(8'h40);
        `CHK(r, RESP_SLVERR)
    endtask : t_regs
    // Latch drives outputs while the board fights back; readback stays the latch.
    task automatic t_latch;
        ext <= 8'hBE;
        wr(OUTPUT_LATCH_OFFSET, 8'h41);
        wr(DIRECTION_OFFSET, 8'h00);
        @(negedge ref_clk);
        `CHK(pin_oe, 8'hC7)
        `CHK(pin_out & 8'hC7, 8'h41)
        ck(OUTPUT_LATCH_OFFSET, 8'h41);
        wr(DIRECTION_OFFSET, 8'hFF);
        ext <= 8'hA5;
        ck(PIN_VALUE_OFFSET, 8'hA5);
        ck(OUTPUT_LATCH_OFFSET, 8'h41);
    endtask : t_latch
    // Peripheral overrides on pins 1, 2, 6 and 7, then the oscillator and input mode.
    task automatic t_periph;
        wr(OUTPUT_LATCH_OFFSET, 8'h00);
        wr(DIRECTION_OFFSET, 8'h00);
        setp(21'h18603C);
        `CHK(pin_out & 8'hC6, 8'hC6)
        setp(21'h1AE03C);
        `CHK(pin_out[7], 1'b0)
        setp(21'h0001D1);
        `CHK({pin_oe[2], pin_out[2]}, 2'b11)
        wr(PIN_CONFIG_OFFSET, 8'h1A);
        @(negedge ref_clk);
        `CHK(pin_oe[2], 1'b0)
        setp(21'h000002);
        `CHK(pin_oe[1:0], 2'b00)
        setp(21'h00600C);
        wr(DIRECTION_OFFSET, 8'hFF);
        ext <= 8'h02;
        @(negedge ref_clk);
        `CHK(pin_oe[6], 1'b0)
        `CHK(cap2, 1'b1)
    endtask : t_periph
    // Input routing with every pin released, then compare two moved to its alternate pin.
    task automatic t_inputs;
        setp(21'h000000);
        ext <= 8'hC5;
        @(negedge ref_clk);
        `CHK(po[1:0], 2'b11)
        `CHK(po[6], 1'b1)
        `CHK(po[8:7], 2'b00)
        setp(21'h008004);
        `CHK(po[8:6], 3'b110)
        wr(PIN_CONFIG_OFFSET, 8'h08);
        @(negedge ref_clk);
        `CHK({po[10], cap2}, 2'b10)
    endtask : t_inputs
    // External transceiver owns pin 1 and reads pins 4 and 5; the on-chip one drives them.
    task automatic t_usb;
        wr(USB_CONTROL_OFFSET, 8'h08);
        wr(PIN_CONFIG_OFFSET, 8'h0E);
        setp(21'h000200);
        ext <= 8'h30;
        @(negedge ref_clk);
        `CHK({pin_oe[1], pin_out[1], po[3:2]}, 4'hF)
        `CHK(pin_oe[5:4], 2'b00)
        ck(PIN_VALUE_OFFSET, 8'h02);
        wr(PIN_CONFIG_OFFSET, 8'h02);
        setp(21'h000C00);
        `CHK({pin_oe[5:4], pin_out[5:4]}, 4'hD)
    endtask : t_usb
    // A hang is cut short well beyond the hundred or so cycles the tests need.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 0;
        t_regs();
        t_latch();
        t_periph();
        t_inputs();
        t_usb();
        conclude();
    end
endmodule : port_c_pin_mux_test
